// >>> hdl/dlk_pkg.sv
// Package for the lock detector and oscillator tuning block.
// Assumes a 32-bit APB register bus and one sample clock.
package dlk_pkg;
	// Register indices, byte address is four times the index
	localparam logic [11:0] IDX_SCALE = 12'h0213;
	localparam logic [11:0] IDX_FTW_LO = 12'h0300;
	localparam logic [11:0] IDX_FTW_HI = 12'h0301;
	localparam logic [11:0] IDX_CLAMP_LO = 12'h0307;
	localparam logic [11:0] IDX_CLAMP_HI = 12'h0308;
	localparam logic [11:0] IDX_POFS = 12'h030D;
	localparam logic [11:0] IDX_PRATE = 12'h0400;
	localparam logic [11:0] IDX_PTHR = 12'h0401;
	localparam logic [11:0] IDX_FRATE = 12'h0402;
	localparam logic [11:0] IDX_FTHR = 12'h0403;
	localparam logic [11:0] IDX_HMODE = 12'h0404;
	localparam logic [11:0] IDX_STATUS = 12'h0405;
	// Widths and reset values
	localparam int TW_W = 48;
	localparam int LVL_W = 13;
	localparam int PE_W = 24;
	localparam int PD_W = 32;
	localparam logic [23:0] CLAMP_LO_RST = 24'h00_0000;
	localparam logic [23:0] CLAMP_HI_RST = 24'hFF_FFFF;
	localparam logic [23:0] CLAMP_FRAC = 24'hFF_FFFF;
	// Leaky bucket marks
	localparam logic signed [LVL_W-1:0] LVL_EMPTY = -13'sd2048;
	localparam logic signed [LVL_W-1:0] LVL_FULL = 13'sd2048;
	localparam logic signed [LVL_W-1:0] LVL_LOW = -13'sd1024;
	localparam logic signed [LVL_W-1:0] LVL_HIGH = 13'sd1024;
	// Loop operating modes
	typedef enum logic [1:0] {
		MODE_FREERUN,
		MODE_CLOSED,
		MODE_HOLDOVER
	} dlk_mode_type;
	// Detector settings from the active profile
	typedef struct packed {
		logic [7:0] fill;
		logic [7:0] drain;
		logic [23:0] thr;
	} dlk_cfg_type;
endpackage : dlk_pkg

// >>> hdl/dlk_core.sv
// Lock detectors, tuning word selection, clamp and phase accumulator.
// Assumes loop filter, history and mode sources run on pclk.
//
// What this block does
// RQ1 - Each detector level saturates between -2048 and +2048, never wrapping.
// RQ2 - Unlock below -1024, lock above +1024, hold between the marks.
// RQ3 - Fill and drain amounts come from separate 8-bit profile rates.
// RQ4 - Each phase-error sample in closed loop outside switchover causes exactly one fill or one drain.
// RQ5 - Phase threshold is unsigned 16-bit picoseconds against error magnitude.
// RQ6 - Magnitude at or below threshold fills, above drains; sign ignored.
// RQ7 - Outside switchover, free-run or holdover forces the phase detector to report unlocked.
// RQ8 - During reference switchover the detectors keep their prior lock state.
// RQ9 - Frequency detector uses same mechanism on period difference magnitude.
// RQ10 - Frequency threshold is unsigned 24-bit picoseconds.
// RQ11 - Accumulator adds the 48-bit tuning word each cycle modulo 2^48.
// RQ12 - A 16-bit phase offset is added to the accumulator output.
// RQ13 - Tuning word from free-run register, loop filter, or history by mode.
// RQ14 - Output tuning is clamped to 24-bit upper and lower bounds always.
// RQ15 - After reset the clamp spans zero to the full sample rate.
// RQ16 - Words inside the bounds pass unchanged; only outside words clamp.
// RQ17 - Software should pick tuning words above 62.5 MHz output.
// RQ18 - A 10-bit converter scale word is held for the output converter.
// RQ19 - Holdover without history uses free-run or last word per fallback bit.
// RQ20 - Both detectors reset empty and unlocked, with separate settings.
// RQ21 - Profile registers supply rates and thresholds, used as they change.
//
// Local design decision: the APB slave port.
`timescale 1ns/10ps
module dlk_core (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Loop state
	input wire dlk_pkg::dlk_mode_type loop_mode,
	input wire logic switchover,
	// Phase detector samples
	input wire logic pe_valid,
	input wire logic signed [dlk_pkg::PE_W-1:0] pe_sample,
	// Period difference samples
	input wire logic pd_valid,
	input wire logic signed [dlk_pkg::PD_W-1:0] pd_sample,
	// Tuning word sources
	input wire logic [dlk_pkg::TW_W-1:0] filter_tw,
	input wire logic [dlk_pkg::TW_W-1:0] history_tw,
	input wire logic history_valid,
	// Outputs
	output logic phase_locked,
	output logic freq_locked,
	output logic [dlk_pkg::TW_W-1:0] frequency_tuning_word,
	output logic [15:0] phase_word,
	output logic [9:0] converter_scale_word
);

	// Merge write data into a register under byte strobes
	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	// Saturating fill or drain of a level
	function automatic logic signed [dlk_pkg::LVL_W-1:0] bucket(
		input logic signed [dlk_pkg::LVL_W-1:0] lvl,
		input logic fill, input logic [7:0] fr, input logic [7:0] dr);
		logic signed [dlk_pkg::LVL_W:0] s;
		s = fill ? lvl + $signed({6'h00, fr}) : lvl - $signed({6'h00, dr});
		if (s > dlk_pkg::LVL_FULL) begin
			s = dlk_pkg::LVL_FULL;
		end else if (s < dlk_pkg::LVL_EMPTY) begin
			s = dlk_pkg::LVL_EMPTY;
		end
		return s[dlk_pkg::LVL_W-1:0];
	endfunction : bucket

	// Hysteresis between the low and high marks
	function automatic logic hyst(input logic signed [dlk_pkg::LVL_W-1:0] lvl,
		input logic prev);
		if (lvl > dlk_pkg::LVL_HIGH) begin
			return 1'b1;
		end else if (lvl < dlk_pkg::LVL_LOW) begin
			return 1'b0;
		end
		return prev;
	endfunction : hyst

	localparam int PE_W = dlk_pkg::PE_W;
	localparam int PD_W = dlk_pkg::PD_W;
	logic [9:0] scale_r;
	logic [47:0] ftw_free_r;
	logic [23:0] clamp_lo_r;
	logic [23:0] clamp_hi_r;
	logic [15:0] pofs_r;
	dlk_pkg::dlk_cfg_type pcfg_r;
	dlk_pkg::dlk_cfg_type fcfg_r;
	logic fallback_r;
	logic [31:0] prdata_r;
	logic signed [dlk_pkg::LVL_W-1:0] plvl_r;
	logic signed [dlk_pkg::LVL_W-1:0] flvl_r;
	logic signed [dlk_pkg::LVL_W-1:0] plvl_nxt;
	logic signed [dlk_pkg::LVL_W-1:0] flvl_nxt;
	logic plock_r;
	logic flock_r;
	logic [47:0] tw_sel;
	logic [47:0] tw_nxt;
	logic [47:0] tw_r;
	logic [47:0] last_tw_r;
	logic [47:0] acc_r;
	logic [15:0] phase_r;
	logic [11:0] idx;
	logic mapped;
	logic wr_en;
	logic [PE_W-1:0] pe_mag;
	logic [PD_W-1:0] pd_mag;
	logic pfill;
	logic ffill;

	// Address decode; the low two bits select nothing
	assign idx = paddr[13:2];
	assign wr_en = psel & penable & pwrite;
	always_comb begin
		case (idx)
			dlk_pkg::IDX_SCALE, dlk_pkg::IDX_FTW_LO, dlk_pkg::IDX_FTW_HI,
			dlk_pkg::IDX_CLAMP_LO, dlk_pkg::IDX_CLAMP_HI, dlk_pkg::IDX_POFS,
			dlk_pkg::IDX_PRATE, dlk_pkg::IDX_PTHR, dlk_pkg::IDX_FRATE,
			dlk_pkg::IDX_FTHR, dlk_pkg::IDX_HMODE, dlk_pkg::IDX_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// Zero wait states; unmapped access answers with an error
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_r;

	// Register writes; profile values take effect on the next sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scale_r <= '0;
			ftw_free_r <= '0;
			// RQ15 clamp fully open
			clamp_lo_r <= dlk_pkg::CLAMP_LO_RST;
			clamp_hi_r <= dlk_pkg::CLAMP_HI_RST;
			pofs_r <= '0;
			pcfg_r <= '0;
			fcfg_r <= '0;
			fallback_r <= 1'b0;
		end else if (wr_en) begin
			case (idx)
				// RQ18 scale word store
				dlk_pkg::IDX_SCALE: scale_r <= 10'(wmerge({22'h0, scale_r}, pwdata,
					pstrb));
				dlk_pkg::IDX_FTW_LO: ftw_free_r[31:0] <= wmerge(ftw_free_r[31:0],
					pwdata, pstrb);
				dlk_pkg::IDX_FTW_HI: ftw_free_r[47:32] <= 16'(wmerge({16'h0,
					ftw_free_r[47:32]}, pwdata, pstrb));
				dlk_pkg::IDX_CLAMP_LO: clamp_lo_r <= 24'(wmerge({8'h0, clamp_lo_r},
					pwdata, pstrb));
				dlk_pkg::IDX_CLAMP_HI: clamp_hi_r <= 24'(wmerge({8'h0, clamp_hi_r},
					pwdata, pstrb));
				dlk_pkg::IDX_POFS: pofs_r <= 16'(wmerge({16'h0, pofs_r}, pwdata,
					pstrb));
				// RQ3 separate rates
				dlk_pkg::IDX_PRATE: {pcfg_r.drain, pcfg_r.fill} <= 16'(wmerge({16'h0,
					pcfg_r.drain, pcfg_r.fill}, pwdata, pstrb));
				// RQ5 16-bit phase threshold
				dlk_pkg::IDX_PTHR: pcfg_r.thr <= {8'h00, 16'(wmerge({16'h0,
					pcfg_r.thr[15:0]}, pwdata, pstrb))};
				dlk_pkg::IDX_FRATE: {fcfg_r.drain, fcfg_r.fill} <= 16'(wmerge({16'h0,
					fcfg_r.drain, fcfg_r.fill}, pwdata, pstrb));
				// RQ10 24-bit frequency threshold
				dlk_pkg::IDX_FTHR: fcfg_r.thr <= 24'(wmerge({8'h0, fcfg_r.thr}, pwdata,
					pstrb));
				dlk_pkg::IDX_HMODE: fallback_r <= 1'(wmerge({31'h0, fallback_r}, pwdata,
					pstrb));
				default: ;
			endcase
		end
	end

	// Read data captured in the setup cycle so it stands from flip-flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
		end else if (psel & ~penable & ~pwrite) begin
			case (idx)
				dlk_pkg::IDX_SCALE: prdata_r <= {22'h0, scale_r};
				dlk_pkg::IDX_FTW_LO: prdata_r <= ftw_free_r[31:0];
				dlk_pkg::IDX_FTW_HI: prdata_r <= {16'h0, ftw_free_r[47:32]};
				dlk_pkg::IDX_CLAMP_LO: prdata_r <= {8'h0, clamp_lo_r};
				dlk_pkg::IDX_CLAMP_HI: prdata_r <= {8'h0, clamp_hi_r};
				dlk_pkg::IDX_POFS: prdata_r <= {16'h0, pofs_r};
				dlk_pkg::IDX_PRATE: prdata_r <= {16'h0, pcfg_r.drain, pcfg_r.fill};
				dlk_pkg::IDX_PTHR: prdata_r <= {16'h0, pcfg_r.thr[15:0]};
				dlk_pkg::IDX_FRATE: prdata_r <= {16'h0, fcfg_r.drain, fcfg_r.fill};
				dlk_pkg::IDX_FTHR: prdata_r <= {8'h0, fcfg_r.thr};
				dlk_pkg::IDX_HMODE: prdata_r <= {31'h0, fallback_r};
				dlk_pkg::IDX_STATUS: prdata_r <= {28'h0, loop_mode, flock_r, plock_r};
				default: prdata_r <= '0;
			endcase
		end
	end

	// RQ6 magnitude only, sign ignored
	assign pe_mag = pe_sample[PE_W-1] ? PE_W'(-pe_sample) : PE_W'(pe_sample);
	assign pd_mag = pd_sample[PD_W-1] ? PD_W'(-pd_sample) : PD_W'(pd_sample);
	assign pfill = pe_mag <= PE_W'({8'h00, pcfg_r.thr[15:0]});
	// RQ9 period difference decision
	assign ffill = pd_mag <= PD_W'(fcfg_r.thr);

	// RQ4 one fill or drain per sample
	// RQ21 live profile values
	assign plvl_nxt = bucket(plvl_r, pfill, pcfg_r.fill, pcfg_r.drain);
	assign flvl_nxt = bucket(flvl_r, ffill, fcfg_r.fill, fcfg_r.drain);

	// Phase detector; switchover freezes level and indication
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// RQ20 start empty, unlocked
			plvl_r <= dlk_pkg::LVL_EMPTY;
			plock_r <= 1'b0;
		end else if (switchover) begin
			// RQ8 hold prior state
			plvl_r <= plvl_r;
		end else if (loop_mode != dlk_pkg::MODE_CLOSED) begin
			// RQ7 open loop reports unlocked
			plock_r <= 1'b0;
		end else if (pe_valid) begin
			// RQ1 saturating level
			plvl_r <= plvl_nxt;
			// RQ2 hysteresis marks
			plock_r <= hyst(plvl_nxt, plock_r);
		end
	end

	// Frequency detector, same mechanism on its own settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flvl_r <= dlk_pkg::LVL_EMPTY;
			flock_r <= 1'b0;
		end else if (pd_valid && !switchover) begin
			// RQ9 shared fill and drain
			flvl_r <= flvl_nxt;
			flock_r <= hyst(flvl_nxt, flock_r);
		end
	end

	// RQ13 source by mode
	always_comb begin
		case (loop_mode)
			dlk_pkg::MODE_CLOSED: tw_sel = filter_tw;
			// RQ19 fallback without history
			dlk_pkg::MODE_HOLDOVER: tw_sel = history_valid ? history_tw :
				(fallback_r ? last_tw_r : ftw_free_r);
			default: tw_sel = ftw_free_r;
		endcase
	end

	// RQ14 clamp in every mode
	always_comb begin
		// RQ16 pass values within bounds
		if (tw_sel < {clamp_lo_r, 24'h00_0000}) begin
			tw_nxt = {clamp_lo_r, 24'h00_0000};
		end else if (tw_sel > {clamp_hi_r, dlk_pkg::CLAMP_FRAC}) begin
			tw_nxt = {clamp_hi_r, dlk_pkg::CLAMP_FRAC};
		end else begin
			tw_nxt = tw_sel;
		end
	end

	// Applied word, and the last closed-loop word for fallback
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tw_r <= '0;
			last_tw_r <= '0;
		end else begin
			tw_r <= tw_nxt;
			if (loop_mode == dlk_pkg::MODE_CLOSED) begin
				last_tw_r <= tw_nxt;
			end
		end
	end

	// Accumulator; the sum wraps naturally at 48 bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_r <= '0;
			phase_r <= '0;
		end else begin
			// RQ11 modulo add
			acc_r <= 48'(acc_r + tw_r);
			// RQ12 phase offset
			phase_r <= 16'(acc_r[47:32] + pofs_r);
		end
	end

	assign phase_locked = plock_r;
	assign freq_locked = flock_r;
	assign frequency_tuning_word = tw_r;
	assign phase_word = phase_r;
	assign converter_scale_word = scale_r;

	// Checks
	AST_SAT: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
		plvl_r <= dlk_pkg::LVL_FULL && plvl_r >= dlk_pkg::LVL_EMPTY)
		else $error("phase level out of range");
	AST_LOCK: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		!$past(plock_r) && plock_r |-> plvl_r > dlk_pkg::LVL_HIGH)
		else $error("lock without high mark");
	AST_UNLOCK: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
		plock_r |-> plvl_r >= dlk_pkg::LVL_LOW)
		else $error("lock held below low mark");
	AST_ONE: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
		pe_valid && !switchover && loop_mode == dlk_pkg::MODE_CLOSED
		|=> plvl_r == $past(plvl_nxt))
		else $error("sample did not update level");
	AST_OPEN: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
		loop_mode != dlk_pkg::MODE_CLOSED && !switchover |=> !plock_r)
		else $error("locked in open loop");
	AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
		switchover |=> $stable(plock_r) && $stable(flock_r))
		else $error("lock changed in switchover");
	AST_ACC: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
		##1 acc_r == 48'($past(acc_r) + $past(tw_r)))
		else $error("accumulator step wrong");
	AST_CLAMP: assert property (@(posedge pclk) disable iff (!presetn) // RQ14
		##1 tw_r >= {$past(clamp_lo_r), 24'h00_0000} &&
		tw_r <= {$past(clamp_hi_r), dlk_pkg::CLAMP_FRAC})
		else $error("tuning word outside clamp");
	AST_FREE: assert property (@(posedge pclk) disable iff (!presetn) // RQ13
		loop_mode == dlk_pkg::MODE_FREERUN && ftw_free_r >= {clamp_lo_r, 24'h0}
		&& ftw_free_r <= {clamp_hi_r, dlk_pkg::CLAMP_FRAC}
		|=> tw_r == $past(ftw_free_r))
		else $error("free-run word not applied");

endmodule : dlk_core

// >>> tb/dlk_far_model.sv
// Far-side model: phase detector, period monitor, loop filter, history.
// Assumes bench requests, one sample per requesting cycle.
`timescale 1ns/10ps
module dlk_far_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench requests
	input wire logic pe_go,
	input wire logic pd_go,
	input wire logic [31:0] err,
	input wire logic [47:0] tw_set,
	input wire logic hist_set,
	// Toward the block
	output logic pe_valid,
	output logic signed [23:0] pe_sample,
	output logic pd_valid,
	output logic signed [31:0] pd_sample,
	output logic [47:0] filter_tw,
	output logic [47:0] history_tw,
	output logic history_valid
);
	logic flip_r;
	// Sign alternates per sample; idle lines invert so stale data never looks valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flip_r <= 1'b0;
			pe_valid <= 1'b0;
			pd_valid <= 1'b0;
			pe_sample <= 24'h00_0000;
			pd_sample <= 32'h0000_0000;
		end else begin
			flip_r <= flip_r ^ (pe_go | pd_go);
			pe_valid <= pe_go;
			pd_valid <= pd_go;
			pe_sample <= pe_go ? (flip_r ? -err[23:0] : err[23:0]) : ~pe_sample;
			pd_sample <= pd_go ? (flip_r ? -err : err) : ~pd_sample;
		end
	end
	// Filter word and history word, history is offset by one step
	always_ff @(posedge pclk) begin
		filter_tw <= tw_set;
		history_tw <= tw_set + 48'h0000_0000_0001;
		history_valid <= hist_set;
	end
endmodule : dlk_far_model

// >>> tb/dlk_core_tb_top.sv
// Bench for the lock detector and tuning block.
// Assumes a zero-wait APB slave and the far-side model.
`timescale 1ns/10ps
module dlk_core_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic pe_go = 1'b0, pd_go = 1'b0, switchover = 1'b0, hist_set = 1'b0, pl = 1'b0, fl = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, err = 32'h0000_0000, prdata;
	logic [3:0] pstrb = 4'hF;
	logic [47:0] tw_set = 48'h0000_0000_0000, tw, lastw, ftw_o, filter_tw, history_tw;
	dlk_pkg::dlk_mode_type loop_mode = dlk_pkg::MODE_FREERUN;
	logic pready, pslverr, pe_valid, pd_valid, history_valid, phase_locked, freq_locked;
	logic signed [23:0] pe_sample;
	logic signed [31:0] pd_sample;
	logic [15:0] phase_word, p0;
	logic [9:0] scale;
	logic [23:0] thr;
	logic [32:0] expq[$];
	int n_fail = 0, checks = 0, seed = 48, k;
	always #4 pclk = ~pclk;
	dlk_core dlk_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .loop_mode(loop_mode), .switchover(switchover),
		.pe_valid(pe_valid), .pe_sample(pe_sample), .pd_valid(pd_valid), .pd_sample(pd_sample),
		.filter_tw(filter_tw), .history_tw(history_tw), .history_valid(history_valid),
		.phase_locked(phase_locked), .freq_locked(freq_locked),
		.frequency_tuning_word(ftw_o), .phase_word(phase_word), .converter_scale_word(scale));
	dlk_far_model dlk_far_model_inst (.pclk(pclk), .presetn(presetn), .pe_go(pe_go),
		.pd_go(pd_go), .err(err), .tw_set(tw_set), .hist_set(hist_set), .pe_valid(pe_valid),
		.pe_sample(pe_sample), .pd_valid(pd_valid), .pd_sample(pd_sample),
		.filter_tw(filter_tw), .history_tw(history_tw), .history_valid(history_valid));
	task automatic test_done();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// One transfer, held until pready is seen high
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_fail++;
			test_done();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [11:0] idx, input logic [32:0] e);
		expq.push_back(e);
		apb(1'b0, idx, 32'h0000_0000);
	endtask : rd
	task automatic settle();
		repeat (4) @(posedge pclk);
	endtask : settle
	// Burst of n samples on one detector, then idle
	task automatic smp(input logic d, input logic [31:0] e, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge pclk);
			pe_go <= !d;
			pd_go <= d;
			err <= e;
		end
		@(posedge pclk);
		pe_go <= 1'b0;
		pd_go <= 1'b0;
		settle();
	endtask : smp
	function automatic logic [32:0] st();
		return {29'h0, loop_mode, fl, pl};
	endfunction : st
	// Read results are compared against the oldest expectation
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (expq.size() == 0) chk(48'h1, 48'h0);
			else chk({15'h0, pslverr, prdata}, {15'h0, expq.pop_front()});
		end
	end
	// Hang guard at 600 us, far beyond the few microseconds the test runs
	initial begin
		#600_000;
		n_fail++;
		test_done();
	end
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(dlk_pkg::IDX_CLAMP_LO, 33'h0);
		rd(dlk_pkg::IDX_CLAMP_HI, {9'h0, 24'hFF_FFFF});
		rd(dlk_pkg::IDX_STATUS, st());
		chk({freq_locked, phase_locked}, 2'b00);
		rd(12'h3FF, {1'b1, 32'h0});
		tw = 48'({$random(seed), $random(seed)});
		apb(1'b1, dlk_pkg::IDX_SCALE, tw[31:0]);
		settle();
		chk(scale, tw[9:0]);
		$display("test regs done");
		// Free-run word kept above the minimum output frequency
		tw = 48'({$random(seed), $random(seed)}) | 48'h1000_0000_0000;
		apb(1'b1, dlk_pkg::IDX_FTW_LO, tw[31:0]);
		apb(1'b1, dlk_pkg::IDX_FTW_HI, {16'h0, tw[47:32]});
		settle();
		chk(ftw_o, tw);
		lastw = ~tw;
		loop_mode <= dlk_pkg::MODE_CLOSED;
		tw_set <= lastw;
		settle();
		chk(ftw_o, lastw);
		hist_set <= 1'b1;
		loop_mode <= dlk_pkg::MODE_HOLDOVER;
		settle();
		chk(ftw_o, lastw + 48'h1);
		hist_set <= 1'b0;
		settle();
		chk(ftw_o, tw);
		apb(1'b1, dlk_pkg::IDX_HMODE, 32'h0000_0001);
		settle();
		chk(ftw_o, lastw);
		loop_mode <= dlk_pkg::MODE_CLOSED;
		apb(1'b1, dlk_pkg::IDX_CLAMP_HI, 32'h0000_0010);
		tw_set <= 48'hFFFF_0000_0000;
		settle();
		chk(ftw_o, 48'h0000_10FF_FFFF);
		apb(1'b1, dlk_pkg::IDX_CLAMP_LO, 32'h0000_0008);
		tw_set <= 48'h0000_0000_0000;
		settle();
		chk(ftw_o, 48'h0000_0800_0000);
		tw_set <= 48'h0000_0C12_3456;
		settle();
		chk(ftw_o, 48'h0000_0C12_3456);
		$display("test tuning done");
		// Accumulator steps up, then wraps downward
		apb(1'b1, dlk_pkg::IDX_CLAMP_LO, 32'h0000_0000);
		apb(1'b1, dlk_pkg::IDX_CLAMP_HI, 32'h00FF_FFFF);
		loop_mode <= dlk_pkg::MODE_FREERUN;
		apb(1'b1, dlk_pkg::IDX_FTW_LO, 32'h0000_0000);
		apb(1'b1, dlk_pkg::IDX_POFS, 32'h0000_0000);
		for (k = 0; k < 3; k++) begin
			apb(1'b1, dlk_pkg::IDX_FTW_HI, k == 0 ? 32'h0000_0001 : k == 1 ? 32'h0000_FFFF : 0);
			settle();
			p0 = phase_word;
			@(posedge pclk);
			p0 = phase_word - p0;
			chk(p0, k == 0 ? 16'h0001 : k == 1 ? 16'hFFFF : 16'h0000);
		end
		p0 = phase_word;
		tw[15:0] = 16'($random(seed));
		apb(1'b1, dlk_pkg::IDX_POFS, {16'h0, tw[15:0]});
		settle();
		p0 = phase_word - p0;
		chk(p0, tw[15:0]);
		$display("test phase done");
		// Fill 200, drain 100: lock on 16th fill, unlock on 31st drain from full
		loop_mode <= dlk_pkg::MODE_CLOSED;
		apb(1'b1, dlk_pkg::IDX_PRATE, 32'h0000_64C8);
		apb(1'b1, dlk_pkg::IDX_FRATE, 32'h0000_64C8);
		for (k = 0; k < 2; k++) begin
			thr = $random(seed) & (k ? 24'h7F_FFFF : 24'h00_7FFF);
			apb(1'b1, k ? dlk_pkg::IDX_FTHR : dlk_pkg::IDX_PTHR, {8'h0, thr});
			smp(k[0], {8'h0, thr}, 15);
			rd(dlk_pkg::IDX_STATUS, st());
			chk({freq_locked, phase_locked}, {fl, pl});
			smp(k[0], {8'h0, thr}, 1);
			{fl, pl} = {k[0], !k[0]};
			rd(dlk_pkg::IDX_STATUS, st());
			chk({freq_locked, phase_locked}, {fl, pl});
			smp(k[0], {8'h0, thr}, 20);
			smp(k[0], {8'h0, thr + 24'h1}, 30);
			rd(dlk_pkg::IDX_STATUS, st());
			chk({freq_locked, phase_locked}, {fl, pl});
			smp(k[0], {8'h0, thr + 24'h1}, 1);
			{fl, pl} = 2'b00;
			rd(dlk_pkg::IDX_STATUS, st());
			chk({freq_locked, phase_locked}, {fl, pl});
		end
		// Lock held through switchover, dropped in free-run
		apb(1'b1, dlk_pkg::IDX_PTHR, 32'h0000_0000);
		smp(1'b0, 32'h0, 16);
		pl = 1'b1;
		switchover <= 1'b1;
		smp(1'b0, 32'h1, 40);
		rd(dlk_pkg::IDX_STATUS, st());
		chk({freq_locked, phase_locked}, {fl, pl});
		switchover <= 1'b0;
		loop_mode <= dlk_pkg::MODE_FREERUN;
		pl = 1'b0;
		settle();
		rd(dlk_pkg::IDX_STATUS, st());
		chk({freq_locked, phase_locked}, {fl, pl});
		settle();
		$display("test lock done");
		test_done();
	end
endmodule : dlk_core_tb_top
